// file: core/sac_pkg.sv
// Shared constants and types for the successive-approximation converter control.
package sac_pkg;
   localparam int unsigned RES_BITS       = 8;
   localparam logic [7:0]  RESULT_RST     = 8'h00;
   localparam int unsigned CLK_MHZ        = 125;
   localparam int unsigned CONV_TIME_US   = 70;
   localparam int unsigned CONV_CYCLES    = CONV_TIME_US * CLK_MHZ;
   localparam int unsigned STEP_CYCLES    = CONV_CYCLES / RES_BITS;
   localparam int unsigned SETTLE_CYCLES  = 4;

   typedef enum logic [1:0] {
      SAC_IDLE,
      SAC_SAMPLE,
      SAC_STEP
   } sac_state_t;

   typedef struct packed {
      logic power_off_bit;
      logic conv_irq_enable;
   } sac_ctrl_t;
endpackage : sac_pkg

// file: core/sac_core.sv
// Sequencer for an 8-bit successive-approximation converter.
`timescale 1ns/1ps
module sac_core
   import sac_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       ctrl_we,
   input  wire sac_ctrl_t  ctrl_wdata,
   input  wire logic       conversion_start_bit,
   input  wire logic       cmp_above,
   output logic            analog_power_en,
   output logic            sample_en,
   output logic [7:0]      dac_code,
   output logic [7:0]      result_data,
   output logic            eoc_flag,
   output logic            start_readback,
   output logic            conv_irq_enable,
   output logic            power_off_bit,
   output logic            conv_irq
);
   logic        rst_meta_r;
   logic        rst_sync_r;
   logic        cmp_meta_r;
   logic        cmp_sync_r;
   sac_state_t  state_r;
   logic [2:0]  bit_idx_r;
   logic [7:0]  sar_r;
   logic [15:0] cnt_r;
   logic        start_go;
   logic        step_done;

   localparam logic [15:0] STEP_LAST   = 16'(STEP_CYCLES - 1);
   localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYCLES - 1);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // Comparator output is analog-derived, so it is synchronised first.
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         cmp_meta_r <= 1'b0;
         cmp_sync_r <= 1'b0;
      end else begin
         cmp_meta_r <= cmp_above;
         cmp_sync_r <= cmp_meta_r;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         power_off_bit   <= 1'b1;
         conv_irq_enable <= 1'b0;
      end else if (ctrl_we) begin
         power_off_bit   <= ctrl_wdata.power_off_bit;
         conv_irq_enable <= ctrl_wdata.conv_irq_enable;
      end
   end

   // A start while powered down is ignored; the analog core cannot convert.
   assign start_go  = conversion_start_bit && !power_off_bit;
   assign step_done = (cnt_r == STEP_LAST);

   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         state_r   <= SAC_IDLE;
         bit_idx_r <= 3'h7;
         sar_r     <= 8'h00;
         cnt_r     <= 16'h0000;
      end else if (start_go) begin
         state_r   <= SAC_SAMPLE;
         bit_idx_r <= 3'h7;
         sar_r     <= 8'h80;
         cnt_r     <= 16'h0000;
      end else if (power_off_bit) begin
         state_r <= SAC_IDLE;
         cnt_r   <= 16'h0000;
      end else begin
         unique case (state_r)
            SAC_IDLE: begin
               cnt_r <= 16'h0000;
            end
            SAC_SAMPLE: begin
               if (cnt_r == SETTLE_LAST) begin
                  state_r <= SAC_STEP;
                  cnt_r   <= 16'h0000;
               end else begin
                  cnt_r <= cnt_r + 16'h0001;
               end
            end
            SAC_STEP: begin
               if (step_done) begin
                  cnt_r <= 16'h0000;
                  // Keep the trial bit only when the input is at or above it.
                  sar_r[bit_idx_r] <= cmp_sync_r;
                  if (bit_idx_r != 3'h0) begin
                     sar_r[bit_idx_r - 3'h1] <= 1'b1;
                     bit_idx_r <= bit_idx_r - 3'h1;
                  end else begin
                     state_r <= SAC_IDLE;
                  end
               end else begin
                  cnt_r <= cnt_r + 16'h0001;
               end
            end
         endcase
      end
   end

   wire conv_last = (state_r == SAC_STEP) && step_done && (bit_idx_r == 3'h0)
                    && !start_go && !power_off_bit;

   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         result_data <= RESULT_RST;
      end else if (conv_last) begin
         result_data <= {sar_r[7:1], cmp_sync_r};
      end
   end

   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         eoc_flag <= 1'b0;
      end else if (start_go) begin
         eoc_flag <= 1'b0;
      end else if (conv_last) begin
         eoc_flag <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         conv_irq <= 1'b0;
      end else begin
         // Cleared with the flag on a start write.
         conv_irq <= conv_irq_enable && !start_go && (eoc_flag || conv_last);
      end
   end

   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         analog_power_en <= 1'b0;
         sample_en       <= 1'b0;
         dac_code        <= 8'h00;
         start_readback  <= 1'b0;
      end else begin
         analog_power_en <= !(ctrl_we ? ctrl_wdata.power_off_bit : power_off_bit);
         sample_en       <= (state_r == SAC_SAMPLE);
         dac_code        <= sar_r;
         start_readback  <= 1'b0;
      end
   end
endmodule : sac_core

// file: dv/sac_core_monitor.sv
// Port checker for the converter sequencer.
`timescale 1ns/1ps
module sac_core_monitor (
   input wire logic       clk,
   input wire logic       arst_n,
   input wire logic       ctrl_we,
   input wire logic       conversion_start_bit,
   input wire logic       analog_power_en,
   input wire logic [7:0] dac_code,
   input wire logic [7:0] result_data,
   input wire logic       eoc_flag,
   input wire logic       start_readback,
   input wire logic       conv_irq_enable,
   input wire logic       power_off_bit,
   input wire logic       conv_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_go; conversion_start_bit && !power_off_bit; endsequence
   property p_rb; start_readback == 1'b0; endproperty
   a_rb: assert property (p_rb) else $error("start readback high");
   property p_pw; analog_power_en == !power_off_bit; endproperty
   a_pw: assert property (p_pw) else $error("power state wrong");
   property p_clr; s_go |=> !eoc_flag; endproperty
   a_clr: assert property (p_clr) else $error("flag not cleared");
   property p_irq;
      $rose(eoc_flag) && conv_irq_enable && !conversion_start_bit |=> conv_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");
   property p_flg; conv_irq |-> eoc_flag; endproperty
   a_flg: assert property (p_flg) else $error("irq without flag");
   property p_res; $changed(result_data) |-> $rose(eoc_flag); endproperty
   a_res: assert property (p_res) else $error("result moved early");
   property p_hold;
      eoc_flag && !conversion_start_bit && !ctrl_we |=> eoc_flag && $stable(result_data);
   endproperty
   a_hold: assert property (p_hold) else $error("flag lost");
   property p_msb; s_go |-> ##[1:8] dac_code == 8'h80; endproperty
   a_msb: assert property (p_msb) else $error("no msb trial");
endmodule : sac_core_monitor

// file: dv/sac_src.sv
// Analog source model on the single selected input line.
`timescale 1ns/1ps
module sac_src (
   input  wire logic [7:0] dac_code,
   input  wire logic [9:0] vin,
   output logic            cmp_above
);
   // Levels past the high reference simply stay above every trial code.
   assign cmp_above = vin >= {2'b00, dac_code};
endmodule : sac_src

// file: dv/sac_core_tb_top.sv
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ps
module sac_core_tb_top;
   import sac_pkg::*;
   logic       clk = 0, arst_n = 0, ctrl_we = 0, start = 0;
   sac_ctrl_t  wd = '0;
   logic       cmp, pwr, smp, eoc, rb, ie, po, irq;
   logic [7:0] dac, res;
   logic [9:0] vin = '0;
   int         err_total = 0, checked = 0, n;
   int         exp_q[$];
   always #4 clk = ~clk;
   sac_core i_dut (.clk(clk), .arst_n(arst_n), .ctrl_we(ctrl_we), .ctrl_wdata(wd),
      .conversion_start_bit(start), .cmp_above(cmp), .analog_power_en(pwr), .sample_en(smp),
      .dac_code(dac), .result_data(res), .eoc_flag(eoc), .start_readback(rb),
      .conv_irq_enable(ie), .power_off_bit(po), .conv_irq(irq));
   sac_src i_src (.dac_code(dac), .vin(vin), .cmp_above(cmp));
   task automatic chk(string s, logic [7:0] e, logic [7:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s exp %h got %h", s, e, g);
      end
   endtask : chk
   task automatic finish_test;
      if (err_total == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   task automatic wr(logic p, logic e);
      @(negedge clk);
      ctrl_we = 1'b1;
      wd = '{p, e};
      @(negedge clk);
      ctrl_we = 1'b0;
   endtask : wr
   task automatic go(logic [9:0] v);
      vin = v;
      exp_q.delete();
      exp_q.push_back(v > 255 ? 255 : v);
      @(negedge clk);
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      n = 1;
   endtask : go
   task automatic fin(logic e);
      while (eoc !== 1'b1 && n < 9000) begin
         @(negedge clk);
         n++;
      end
      chk("time", 1, n >= 4 + 8 * STEP_CYCLES && n <= 6 + 8 * STEP_CYCLES);
      chk("result", 8'(exp_q.pop_front()), res);
      @(negedge clk);
      chk("irq", e, irq);
   endtask : fin
   initial begin
      void'($urandom(32733));
      repeat (16) @(negedge clk);
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
      chk("eoc", 0, eoc);
      chk("ie", 0, ie);
      go(10'd5);
      repeat (20) @(negedge clk);
      chk("sample", 0, smp);
      wr(1'b0, 1'b1);
      @(negedge clk);
      chk("power", 1, pwr);
      for (int i = 0; i < 4; i++) begin
         wr(1'b0, i != 3);
         go(i == 0 ? 10'd0 : i == 1 ? 10'd300 : 10'($urandom_range(1, 254)));
         fin(i != 3);
      end
      go(10'd100);
      @(negedge clk);
      chk("sample", 1, smp);
      wr(1'b1, 1'b0);
      chk("power", 0, pwr);
      repeat (9000) @(negedge clk);
      chk("abort", 0, eoc);
      wr(1'b0, 1'b0);
      go(10'd200);
      repeat (3000) @(negedge clk);
      go(10'($urandom_range(0, 255)));
      fin(1'b0);
      repeat (50) @(negedge clk);
      chk("hold", 1, eoc);
      finish_test;
   end
   // Four conversions of about 8750 cycles plus the aborted one and the restarted one fit inside this span.
   initial begin
      repeat (80000) @(posedge clk);
      err_total++;
      finish_test;
   end
endmodule : sac_core_tb_top
bind sac_core sac_core_monitor i_mon (.clk(clk), .arst_n(arst_n), .ctrl_we(ctrl_we),
   .conversion_start_bit(conversion_start_bit), .analog_power_en(analog_power_en),
   .dac_code(dac_code), .result_data(result_data), .eoc_flag(eoc_flag),
   .start_readback(start_readback), .conv_irq_enable(conv_irq_enable),
   .power_off_bit(power_off_bit), .conv_irq(conv_irq));
